// *** mac_word_end.sv ***
// MAC end: software drives lane words and watches received ones
`timescale 1ns/100ps
`default_nettype none
module mac_word_end
  import word_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  word_map_if.mac link,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);
  logic [31:0] ctrl_ff;
  logic [LANES*TX_W-1:0] txw_ff;
  logic [LANES*RX_W-1:0] rxw_ff;
  logic [LANES-1:0] prev_sync_ff;
  logic [2*LANES-1:0] stat_ff;
  logic [LANES-1:0] err_ev;
  logic [LANES-1:0] sync_ev;
  logic wr_ack_ff;
  logic rd_ack_ff;

  assign link.coding_en = ctrl_ff[0];
  assign link.tx_parallel_data = txw_ff;
  // A set mask bit hides its status bit from the line
  assign irq_o = |(stat_ff & ~ctrl_ff[16+:2*LANES]);
  // Single wait cycle gives registered read data
  assign avs_waitrequest_o = (avs_read_i & ~rd_ack_ff) |
                             (avs_write_i & ~wr_ack_ff);

  // Events per lane: decode/disparity error, loss of sync
  always_comb begin
    for (int k = 0; k < LANES; k++) begin
      err_ev[k] = link.rx_parallel_data[k*RX_W+RX_DERR_BIT] |
                  (ctrl_ff[0] & link.rx_parallel_data[k*RX_W+RX_ERR_BIT]);
      sync_ev[k] = prev_sync_ff[k] &
                   ~link.rx_parallel_data[k*RX_W+RX_SYNC_BIT];
    end
  end

  // Every receive word is taken, no stall possible
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rxw_ff <= '0;
      prev_sync_ff <= '0;
    end else begin
      rxw_ff <= link.rx_parallel_data;
      for (int k = 0; k < LANES; k++) begin
        prev_sync_ff[k] <= link.rx_parallel_data[k*RX_W+RX_SYNC_BIT];
      end
    end
  end

  // Handshake acks last one cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ack_ff <= 1'b0;
      rd_ack_ff <= 1'b0;
    end else begin
      wr_ack_ff <= avs_write_i & ~wr_ack_ff;
      rd_ack_ff <= avs_read_i & ~rd_ack_ff;
    end
  end

  // Control and transmit word registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_ff <= CTRL_RST;
      txw_ff <= '0;
    end else if (avs_write_i & wr_ack_ff) begin
      if (avs_address_i == ADDR_CTRL) begin
        ctrl_ff <= avs_writedata_i;
      end else if (avs_address_i == ADDR_TXW) begin
        txw_ff <= avs_writedata_i[LANES*TX_W-1:0];
      end
    end
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stat_ff <= '0;
    end else if (avs_write_i & wr_ack_ff & (avs_address_i == ADDR_STAT)) begin
      stat_ff <= (stat_ff & ~avs_writedata_i[2*LANES-1:0]) |
                 {sync_ev, err_ev};
    end else begin
      stat_ff <= stat_ff | {sync_ev, err_ev};
    end
  end

  // Read mux; unmapped addresses return zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~rd_ack_ff) begin
      if (avs_address_i == ADDR_CTRL) begin
        avs_readdata_o <= ctrl_ff;
      end else if (avs_address_i == ADDR_TXW) begin
        avs_readdata_o <= 32'(txw_ff);
      end else if (avs_address_i == ADDR_RXW) begin
        avs_readdata_o <= rxw_ff;
      end else if (avs_address_i == ADDR_STAT) begin
        avs_readdata_o <= 32'(stat_ff);
      end else begin
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// *** word_map_pkg.sv ***
// Shared constants for the per-lane parallel word mapping
package word_map_pkg;
  localparam int LANES = 2;
  localparam int TX_W = 11;
  localparam int RX_W = 16;
  // Transmit word fields
  localparam int TX_DATA_MSB = 7;
  localparam int TX_CTRL_BIT = 8;
  localparam int TX_FORCE_BIT = 9;
  localparam int TX_DISP_BIT = 10;
  localparam int RAW_MSB = 9;
  // Receive word fields
  localparam int RX_ERR_BIT = 9;
  localparam int RX_SYNC_BIT = 10;
  localparam int RX_DERR_BIT = 11;
  localparam int RX_PAT_BIT = 12;
  localparam int RX_RM_LSB = 13;
  localparam int RX_RDISP_BIT = 15;
  // Rate-match codes
  localparam logic [1:0] RM_NORMAL = 2'h0;
  localparam logic [1:0] RM_DELETE = 2'h1;
  localparam logic [1:0] RM_INSERT = 2'h2;
  localparam logic [1:0] RM_UNDER = 2'h3;
  localparam logic [1:0] RM_OVER = 2'h3;
  localparam logic [8:0] UNDER_SYM_A = 9'h1FE;
  localparam logic [8:0] UNDER_SYM_B = 9'h1F7;
  // Forced disparity encoding
  localparam logic DISP_POS = 1'h0;
  localparam logic DISP_NEG = 1'h1;
  // Register bus map (byte addresses) and reset values
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TXW = 4'h4;
  localparam logic [3:0] ADDR_RXW = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
endpackage

// *** word_map_if.sv ***
// Interface joining the transceiver lane end and the MAC end
`timescale 1ns/100ps
`default_nettype none
interface word_map_if
  import word_map_pkg::*;
();
  logic [LANES*TX_W-1:0] tx_parallel_data;
  logic [LANES*RX_W-1:0] rx_parallel_data;
  logic coding_en;
  modport pcs (input tx_parallel_data, input coding_en,
               output rx_parallel_data);
  modport mac (output tx_parallel_data, output coding_en,
               input rx_parallel_data);
endinterface
`default_nettype wire

// *** lane_mapper.sv ***
// One lane: decodes a transmit word and packs a receive word
`timescale 1ns/100ps
`default_nettype none
module lane_mapper
  import word_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic coding_en_i,
  input wire logic [TX_W-1:0] tx_word_i,
  input wire logic [9:0] rx_sym_i,
  input wire logic rx_ctrl_i,
  input wire logic rx_err_i,
  input wire logic rx_sync_i,
  input wire logic rx_derr_i,
  input wire logic rx_pat_i,
  input wire logic [1:0] rx_rm_i,
  input wire logic rx_rdisp_i,
  output logic [9:0] tx_sym_o,
  output logic tx_ctrl_o,
  output logic tx_force_o,
  output logic tx_disp_o,
  output logic [RX_W-1:0] rx_word_o
);
  logic [RX_W-1:0] nxt_rx_word;

  // Transmit field split; raw mode ignores bit 10
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_sym_o <= 10'h000;
      tx_ctrl_o <= 1'b0;
      tx_force_o <= 1'b0;
      tx_disp_o <= 1'b0;
    end else if (coding_en_i) begin
      tx_sym_o <= {2'h0, tx_word_i[TX_DATA_MSB:0]};
      tx_ctrl_o <= tx_word_i[TX_CTRL_BIT];
      tx_force_o <= tx_word_i[TX_FORCE_BIT];
      // Disparity only meaningful while forcing
      tx_disp_o <= tx_word_i[TX_FORCE_BIT] &
                   tx_word_i[TX_DISP_BIT];
    end else begin
      tx_sym_o <= tx_word_i[RAW_MSB:0];
      tx_ctrl_o <= 1'b0;
      tx_force_o <= 1'b0;
      tx_disp_o <= 1'b0;
    end
  end

  // Receive packing; one status set per symbol
  always_comb begin
    nxt_rx_word = '0;
    if (coding_en_i) begin
      nxt_rx_word[TX_DATA_MSB:0] = rx_sym_i[7:0];
      nxt_rx_word[TX_CTRL_BIT] = rx_ctrl_i;
      nxt_rx_word[RX_ERR_BIT] = rx_err_i;
      nxt_rx_word[RX_RM_LSB+:2] = rx_rm_i;
    end else begin
      nxt_rx_word[RAW_MSB:0] = rx_sym_i;
      // Second code table: 2'b11 reads as overflow here
      nxt_rx_word[RX_RM_LSB+:2] = rx_rm_i;
    end
    nxt_rx_word[RX_SYNC_BIT] = rx_sync_i;
    nxt_rx_word[RX_DERR_BIT] = rx_derr_i;
    nxt_rx_word[RX_PAT_BIT] = rx_pat_i;
    nxt_rx_word[RX_RDISP_BIT] = rx_rdisp_i;
  end

  // Data and status share one edge so they stay aligned
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_word_o <= '0;
    end else begin
      rx_word_o <= nxt_rx_word;
    end
  end
endmodule
`default_nettype wire

// *** pcs_word_end.sv ***
// Transceiver end: maps lane words between MAC and symbol paths
`timescale 1ns/100ps
`default_nettype none
module pcs_word_end
  import word_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  word_map_if.pcs link,
  input wire logic [LANES*10-1:0] rx_sym_i,
  input wire logic [LANES-1:0] rx_ctrl_i,
  input wire logic [LANES-1:0] rx_err_i,
  input wire logic [LANES-1:0] rx_sync_i,
  input wire logic [LANES-1:0] rx_derr_i,
  input wire logic [LANES-1:0] rx_pat_i,
  input wire logic [LANES*2-1:0] rx_rm_i,
  input wire logic [LANES-1:0] rx_rdisp_i,
  output logic [LANES*10-1:0] tx_sym_o,
  output logic [LANES-1:0] tx_ctrl_o,
  output logic [LANES-1:0] tx_force_o,
  output logic [LANES-1:0] tx_disp_o
);
  // clk_i stands for the recovered parallel clock
  // One mapper per lane, slice k from the LSB; no ready path
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    lane_mapper u_lane (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .coding_en_i(link.coding_en),
      .tx_word_i(link.tx_parallel_data[k*TX_W+:TX_W]),
      .rx_sym_i(rx_sym_i[k*10+:10]),
      .rx_ctrl_i(rx_ctrl_i[k]),
      .rx_err_i(rx_err_i[k]),
      .rx_sync_i(rx_sync_i[k]),
      .rx_derr_i(rx_derr_i[k]),
      .rx_pat_i(rx_pat_i[k]),
      .rx_rm_i(rx_rm_i[k*2+:2]),
      .rx_rdisp_i(rx_rdisp_i[k]),
      .tx_sym_o(tx_sym_o[k*10+:10]),
      .tx_ctrl_o(tx_ctrl_o[k]),
      .tx_force_o(tx_force_o[k]),
      .tx_disp_o(tx_disp_o[k]),
      .rx_word_o(link.rx_parallel_data[k*RX_W+:RX_W])
    );
  end
endmodule
`default_nettype wire

// *** word_map_sva.sv ***
// Assertions on the lane words crossing between the two ends
`timescale 1ns/100ps
`default_nettype none
module word_map_sva
  import word_map_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [LANES*TX_W-1:0] tx_parallel_data,
  input wire logic [LANES*RX_W-1:0] rx_parallel_data,
  input wire logic coding_en,
  input wire logic [LANES*10-1:0] tx_sym_o,
  input wire logic [LANES-1:0] tx_ctrl_o,
  input wire logic [LANES-1:0] tx_force_o,
  input wire logic [LANES-1:0] tx_disp_o,
  input wire logic [LANES*10-1:0] rx_sym_i,
  input wire logic [LANES-1:0] rx_ctrl_i,
  input wire logic [LANES-1:0] rx_err_i,
  input wire logic [LANES-1:0] rx_sync_i,
  input wire logic [LANES-1:0] rx_derr_i,
  input wire logic [LANES-1:0] rx_pat_i,
  input wire logic [LANES*2-1:0] rx_rm_i,
  input wire logic [LANES-1:0] rx_rdisp_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic [LANES*TX_W-1:0] t = tx_parallel_data;
  wire logic [LANES*RX_W-1:0] r = rx_parallel_data;
  // Mode at the previous edge; zero after reset so stale words are skipped
  logic [1:0] md_ff;
  always_ff @(posedge clk_i) begin
    md_ff <= reset_i ? 2'h0 : {1'h1, coding_en};
  end
  a_tx_coded_byte: assert property (md_ff == 2'h3 |->
    tx_sym_o[7:0] == $past(t[7:0]) && tx_sym_o[17:10] == $past(t[18:11])
    && tx_ctrl_o == {$past(t[19]), $past(t[8])}) else $error("tx byte bad");
  a_tx_force_flag: assert property (md_ff == 2'h3 |->
    tx_force_o == {$past(t[20]), $past(t[9])}) else $error("tx force bad");
  a_tx_disp_value: assert property (md_ff == 2'h3 |->
    tx_disp_o == {$past(t[21]) & $past(t[20]), $past(t[10]) & $past(t[9])})
    else $error("tx disparity bad");
  a_tx_raw_word: assert property (md_ff == 2'h2 |->
    tx_sym_o == {$past(t[20:11]), $past(t[9:0])}
    && {tx_ctrl_o, tx_force_o, tx_disp_o} == 6'h0) else $error("tx raw bad");
  a_rx_coded_low: assert property (md_ff == 2'h3 |->
    r[9:0] == {$past(rx_err_i[0]), $past(rx_ctrl_i[0]), $past(rx_sym_i[7:0])})
    else $error("rx coded low bits bad");
  a_rx_raw_low: assert property (md_ff == 2'h2 |->
    r[9:0] == $past(rx_sym_i[9:0])) else $error("rx raw bits bad");
  a_rx_status_bits: assert property (md_ff[1] |->
    r[15:10] == {$past(rx_rdisp_i[0]), $past(rx_rm_i[1:0]),
    $past(rx_pat_i[0]), $past(rx_derr_i[0]), $past(rx_sync_i[0])})
    else $error("rx status bits bad");
  a_rx_lane_slice: assert property (md_ff[1] |->
    r[31:26] == {$past(rx_rdisp_i[1]), $past(rx_rm_i[3:2]),
    $past(rx_pat_i[1]), $past(rx_derr_i[1]), $past(rx_sync_i[1])}
    && r[23:16] == $past(rx_sym_i[17:10])) else $error("rx lane one bad");
  // Main traffic kinds
  c_forced: cover property (md_ff == 2'h3 && tx_force_o[0]);
  c_raw: cover property (md_ff == 2'h2);
  c_underflow: cover property (r[14:13] == 2'h3);
endmodule
`default_nettype wire

// *** pcs_parallel_word_mapper_tb.sv ***
// Self-checking bench: MAC end and transceiver end joined by the link
`timescale 1ns/100ps
`default_nettype none
module pcs_parallel_word_mapper_tb
  import word_map_pkg::*;
();
  logic clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [3:0] avs_address_i, rx_rm_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [19:0] rx_sym_i, tx_sym_o;
  logic [1:0] rx_ctrl_i, rx_err_i, rx_sync_i, rx_derr_i, rx_pat_i, rx_rdisp_i;
  logic [1:0] tx_ctrl_o, tx_force_o, tx_disp_o;
  int mismatches, checked;
  word_map_if i_word_map_if();
  pcs_word_end i_pcs_word_end(.clk_i, .reset_i, .link(i_word_map_if),
    .rx_sym_i, .rx_ctrl_i, .rx_err_i, .rx_sync_i, .rx_derr_i, .rx_pat_i,
    .rx_rm_i, .rx_rdisp_i, .tx_sym_o, .tx_ctrl_o, .tx_force_o, .tx_disp_o);
  mac_word_end i_mac_word_end(.clk_i, .reset_i, .link(i_word_map_if),
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .irq_o);
  word_map_sva i_word_map_sva(.clk_i, .reset_i,
    .tx_parallel_data(i_word_map_if.tx_parallel_data),
    .rx_parallel_data(i_word_map_if.rx_parallel_data),
    .coding_en(i_word_map_if.coding_en), .tx_sym_o, .tx_ctrl_o, .tx_force_o,
    .tx_disp_o, .rx_sym_i, .rx_ctrl_i, .rx_err_i, .rx_sync_i, .rx_derr_i,
    .rx_pat_i, .rx_rm_i, .rx_rdisp_i);
  // 100 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycle held until waitrequest is low; a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    {avs_write_i, avs_read_i, avs_address_i} <= {wr, !wr, a};
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'h0);
    rd = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'h0;
  endtask
  // Words pass one edge late; three edges leave margin
  task automatic tx_case(input logic [21:0] w, logic [19:0] s, m,
      logic [5:0] f);
    bus(1'h1, ADDR_TXW, 32'(w));
    repeat (3) @(posedge clk_i);
    chk("tx symbols", s & m, tx_sym_o & m);
    chk("tx flags", 32'(f),
      32'({tx_ctrl_o, tx_force_o, tx_disp_o}));
  endtask
  function automatic logic [15:0] rx_exp(input logic cd, input int k);
    logic [9:0] s;
    s = rx_sym_i[k*10+:10];
    if (cd) s = {rx_err_i[k], rx_ctrl_i[k], s[7:0]};
    return {rx_rdisp_i[k], rx_rm_i[k*2+:2], rx_pat_i[k], rx_derr_i[k],
      rx_sync_i[k], s};
  endfunction
  // Sweep every rate-match code, lanes running opposite codes
  task automatic rx_scan(input logic cd);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {rx_rdisp_i, rx_rm_i, rx_pat_i, rx_derr_i} <=
        {2'(i), 2'(3 - i), 2'(i), 2'(i), ~2'(i)};
      {rx_sync_i, rx_err_i, rx_ctrl_i} <= {2'(i + 1), 2'(i), ~2'(i)};
      rx_sym_i <= 20'h2A5C3 ^ {10{2'(i)}};
      repeat (3) @(posedge clk_i);
      bus(1'h0, ADDR_RXW, 32'h0);
      chk("rx words", {rx_exp(cd, 1), rx_exp(cd, 0)}, rd);
    end
  endtask
  // Error event raises the line, mask hides it, write-one clears it
  task automatic irq_case();
    {rx_err_i, rx_derr_i, rx_sync_i} <= 6'h03;
    bus(1'h1, ADDR_STAT, 32'hF);
    @(posedge clk_i);
    chk("irq idle", 32'h0, 32'(irq_o));
    rx_derr_i <= 2'h1;
    @(posedge clk_i);
    rx_derr_i <= 2'h0;
    repeat (3) @(posedge clk_i);
    chk("irq raised", 32'h1, 32'(irq_o));
    bus(1'h0, ADDR_STAT, 32'h0);
    chk("status", 32'h1, rd & 32'h3);
    bus(1'h1, ADDR_CTRL, 32'h0001_0001);
    @(posedge clk_i);
    chk("irq masked", 32'h0, 32'(irq_o));
    bus(1'h1, ADDR_CTRL, CTRL_RST);
    bus(1'h1, ADDR_STAT, 32'h1);
    bus(1'h0, ADDR_STAT, 32'h0);
    chk("status clear", 32'h0, rd & 32'h3);
    chk("irq clear", 32'h0, 32'(irq_o));
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog at 10000 cycles, well beyond the hundred or so cycles the run needs
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
  initial begin
    reset_i = 1'h1;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {rx_sym_i, rx_ctrl_i, rx_err_i, rx_derr_i, rx_pat_i} = '0;
    {rx_rm_i, rx_rdisp_i, rx_sync_i} = '0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    bus(1'h0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RST, rd);
    bus(1'h0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    tx_case({11'h43C, 11'h3A5}, 20'h0F0A5, 20'h3FCFF, 6'h14);
    tx_case({11'h7FF, 11'h65A}, 20'h3FC5A, 20'h3FCFF, 6'h2F);
    rx_scan(1'h1);
    irq_case();
    bus(1'h1, ADDR_CTRL, 32'h0);
    tx_case({11'h555, 11'h7FF}, 20'h557FF, 20'hFFFFF, 6'h0);
    rx_scan(1'h0);
    test_done();
  end
endmodule
`default_nettype wire
